// file: design/rca_pkg.sv
package rca_pkg;

	// ==========================================================
	// register offsets (byte addresses) and alias operations
	// ==========================================================
	localparam logic [7:0] RCA_OFF_CTRL1 = 8'h00;
	localparam logic [7:0] RCA_OFF_CTRL2 = 8'h10;
	localparam logic [7:0] RCA_OFF_STAT = 8'h30;
	localparam logic [7:0] RCA_OFF_TIME = 8'h40;
	localparam logic [7:0] RCA_OFF_DATE = 8'h50;
	localparam logic [7:0] RCA_OFF_ATIME = 8'h60;
	localparam logic [7:0] RCA_OFF_ADATE = 8'h70;
	localparam logic [1:0] RCA_OP_WRITE = 2'h0;
	localparam logic [1:0] RCA_OP_CLR = 2'h1;
	localparam logic [1:0] RCA_OP_SET = 2'h2;
	localparam logic [1:0] RCA_OP_INV = 2'h3;

	// ==========================================================
	// implemented bits and reset values
	// ==========================================================
	localparam logic [31:0] RCA_IMPL_CTRL1 = 32'hcfff_88f0;
	localparam logic [31:0] RCA_IMPL_CTRL2 = 32'hffff_f803;
	localparam logic [31:0] RCA_IMPL_TIME = 32'h7f7f_ff00;
	localparam logic [31:0] RCA_IMPL_DATE = 32'hff1f_3f07;
	localparam logic [31:0] RCA_IMPL_ADATE = 32'h001f_3f07;
	localparam logic [31:0] RCA_RST_WORD = 32'h0000_0000;

	// ==========================================================
	// control and status field positions
	// ==========================================================
	localparam int RCA_C1_ALARM_EN = 31;
	localparam int RCA_C1_CHIME = 30;
	localparam int RCA_C1_IV_LO = 24;
	localparam int RCA_C1_RPT_LO = 16;
	localparam int RCA_C1_ON = 15;
	localparam int RCA_C1_LOCK = 11;
	localparam int RCA_C1_OE = 7;
	localparam int RCA_C1_OS_LO = 4;
	localparam int RCA_C2_DIV_LO = 16;
	localparam int RCA_C2_CS_LO = 0;
	localparam int RCA_ST_EVT = 5;
	localparam int RCA_ST_SYNC = 2;
	localparam int RCA_ST_ALM_PEND = 1;
	localparam int RCA_ST_HALF = 0;

	// ==========================================================
	// encodings
	// ==========================================================
	localparam logic [3:0] RCA_IV_HALF = 4'h0;
	localparam logic [3:0] RCA_IV_SEC = 4'h1;
	localparam logic [3:0] RCA_IV_TEN_SEC = 4'h2;
	localparam logic [3:0] RCA_IV_MIN = 4'h3;
	localparam logic [3:0] RCA_IV_TEN_MIN = 4'h4;
	localparam logic [3:0] RCA_IV_HOUR = 4'h5;
	localparam logic [3:0] RCA_IV_DAY = 4'h6;
	localparam logic [3:0] RCA_IV_WEEK = 4'h7;
	localparam logic [3:0] RCA_IV_MONTH = 4'h8;
	localparam logic [3:0] RCA_IV_YEAR = 4'h9;
	localparam logic [2:0] RCA_OS_ALARM = 3'h0;
	localparam logic [2:0] RCA_OS_SECONDS = 3'h1;
	localparam logic [2:0] RCA_OS_DIVCLK = 3'h2;
	localparam logic [1:0] RCA_CS_CRYSTAL = 2'h0;
	localparam logic [1:0] RCA_CS_INTOSC = 2'h1;
	localparam logic [1:0] RCA_CS_PIN = 2'h2;
	localparam logic [1:0] RCA_CS_PCLK = 2'h3;

	// ==========================================================
	// bcd limits
	// ==========================================================
	localparam logic [3:0] RCA_NINE = 4'h9;
	localparam logic [3:0] RCA_FIVE = 4'h5;
	localparam logic [2:0] RCA_HR_TENS_MAX = 3'h2;
	localparam logic [3:0] RCA_HR_ONES_MAX = 4'h3;
	localparam logic [2:0] RCA_WDAY_MAX = 3'h6;
	localparam logic [7:0] RCA_DEC_MONTH = 8'h12;
	localparam logic [7:0] RCA_FIRST = 8'h01;
	localparam logic [7:0] RCA_FEB = 8'h02;
	localparam logic [7:0] RCA_LAST_28 = 8'h28;
	localparam logic [7:0] RCA_LAST_29 = 8'h29;
	localparam logic [7:0] RCA_LAST_30 = 8'h30;
	localparam logic [7:0] RCA_LAST_31 = 8'h31;
	localparam logic [7:0] RCA_RPT_FULL = 8'hff;

	typedef struct packed {
		logic [2:0] hr_tens;
		logic [3:0] hr_ones;
		logic [2:0] min_tens;
		logic [3:0] min_ones;
		logic [3:0] sec_tens;
		logic [3:0] sec_ones;
	} rca_time_t;

	typedef struct packed {
		logic [3:0] yr_tens;
		logic [3:0] yr_ones;
		logic mon_tens;
		logic [3:0] mon_ones;
		logic [1:0] day_tens;
		logic [3:0] day_ones;
		logic [2:0] wday;
	} rca_date_t;

endpackage

// file: design/rca_rtc_calendar.sv
`timescale 1ns/10ps
module rca_rtc_calendar
	import rca_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic crystal_oscillator,
	input wire logic internal_slow_oscillator,
	input wire logic external_time_clock_pin,
	input wire logic unlock_granted,
	output logic rtc_pin_out
);

	// ==========================================================
	// helpers
	// ==========================================================
	function automatic logic [31:0] alias_apply(input logic [31:0] old,
		input logic [31:0] wd, input logic [1:0] op, input logic [3:0] sel,
		input logic [31:0] impl);
		logic [31:0] m;
		logic [31:0] r;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & impl;
		r = old;
		unique case (op)
			RCA_OP_WRITE: r = (old & ~m) | (wd & m);
			RCA_OP_CLR: r = old & ~(wd & m);
			RCA_OP_SET: r = old | (wd & m);
			RCA_OP_INV: r = old ^ (wd & m);
		endcase
		return r;
	endfunction

	function automatic logic [31:0] time_word(input rca_time_t t);
		return {1'b0, t.hr_tens, t.hr_ones, 1'b0, t.min_tens, t.min_ones,
			t.sec_tens, t.sec_ones, 8'h00};
	endfunction

	function automatic rca_time_t word_time(input logic [31:0] w);
		rca_time_t t;
		t.hr_tens = w[30:28];
		t.hr_ones = w[27:24];
		t.min_tens = w[22:20];
		t.min_ones = w[19:16];
		t.sec_tens = w[15:12];
		t.sec_ones = w[11:8];
		return t;
	endfunction

	function automatic logic [31:0] date_word(input rca_date_t d);
		return {d.yr_tens, d.yr_ones, 3'h0, d.mon_tens, d.mon_ones, 2'h0,
			d.day_tens, d.day_ones, 5'h00, d.wday};
	endfunction

	function automatic rca_date_t word_date(input logic [31:0] w);
		rca_date_t d;
		d.yr_tens = w[31:28];
		d.yr_ones = w[27:24];
		d.mon_tens = w[20];
		d.mon_ones = w[19:16];
		d.day_tens = w[13:12];
		d.day_ones = w[11:8];
		d.wday = w[2:0];
		return d;
	endfunction

	function automatic logic hit(input logic [7:0] adr,
		input logic [7:0] off);
		return adr[7:4] == off[7:4];
	endfunction

	// bcd last day of month; leap when the bcd year is a multiple of four
	function automatic logic [7:0] last_day(input rca_date_t d);
		logic [7:0] mon;
		logic leap;
		mon = {3'h0, d.mon_tens, d.mon_ones};
		leap = d.yr_tens[0] ? (d.yr_ones == 4'h2 || d.yr_ones == 4'h6) :
			(d.yr_ones == 4'h0 || d.yr_ones == 4'h4 ||
			d.yr_ones == 4'h8);
		if (mon == RCA_FEB) begin
			return leap ? RCA_LAST_29 : RCA_LAST_28;
		end else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 ||
			mon == 8'h11) begin
			return RCA_LAST_30;
		end
		return RCA_LAST_31;
	endfunction

	// ==========================================================
	// registers
	// ==========================================================
	logic [31:0] ctrl1;
	logic [31:0] ctrl2;
	rca_time_t now_time;
	rca_date_t now_date;
	rca_time_t alm_time;
	rca_date_t alm_date;
	logic [15:0] div_cnt;
	logic src_prev;
	logic half_phase;
	logic div_toggle;
	logic eval_pend;
	logic alarm_pulse;
	logic evt_flag;
	logic sync_flag;

	wire logic on = ctrl1[RCA_C1_ON];
	wire logic locked = ctrl1[RCA_C1_LOCK];
	wire logic alarm_en = ctrl1[RCA_C1_ALARM_EN];
	wire logic chime = ctrl1[RCA_C1_CHIME];
	wire logic [3:0] iv = ctrl1[RCA_C1_IV_LO +: 4];
	wire logic [7:0] rpt = ctrl1[RCA_C1_RPT_LO +: 8];
	wire logic [2:0] out_sel = ctrl1[RCA_C1_OS_LO +: 3];
	wire logic [15:0] div_period = ctrl2[RCA_C2_DIV_LO +: 16];
	wire logic [1:0] src_sel = ctrl2[RCA_C2_CS_LO +: 2];

	// ==========================================================
	// wishbone slave
	// ==========================================================
	// ack one cycle after the strobe; writes land on the ack edge
	wire logic req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire logic wr_go = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
	wire logic rd_stat_go = wb_cyc_i & wb_stb_i & ~wb_we_i & wb_ack_o &
		hit(wb_adr_i, RCA_OFF_STAT);
	wire logic [1:0] op = wb_adr_i[3:2];
	logic [31:0] rd_word;
	logic [31:0] stat_word;

	always_comb begin
		stat_word = RCA_RST_WORD;
		stat_word[RCA_ST_EVT] = evt_flag;
		stat_word[RCA_ST_SYNC] = sync_flag;
		stat_word[RCA_ST_ALM_PEND] = eval_pend;
		stat_word[RCA_ST_HALF] = half_phase;
		rd_word = RCA_RST_WORD;
		if (hit(wb_adr_i, RCA_OFF_CTRL1)) begin
			rd_word = ctrl1;
		end else if (hit(wb_adr_i, RCA_OFF_CTRL2)) begin
			rd_word = ctrl2;
		end else if (hit(wb_adr_i, RCA_OFF_STAT)) begin
			rd_word = stat_word;
		end else if (hit(wb_adr_i, RCA_OFF_TIME)) begin
			rd_word = time_word(now_time);
		end else if (hit(wb_adr_i, RCA_OFF_DATE)) begin
			rd_word = date_word(now_date);
		end else if (hit(wb_adr_i, RCA_OFF_ATIME)) begin
			rd_word = time_word(alm_time);
		end else if (hit(wb_adr_i, RCA_OFF_ADATE)) begin
			rd_word = date_word(alm_date);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= RCA_RST_WORD;
		end else if (clk_en) begin
			wb_ack_o <= req;
			wb_dat_o <= req ? rd_word : RCA_RST_WORD;
		end
	end

	// ==========================================================
	// time source and half-second divider
	// ==========================================================
	logic src_level;
	always_comb begin
		unique case (src_sel)
			RCA_CS_CRYSTAL: src_level = crystal_oscillator;
			RCA_CS_INTOSC: src_level = internal_slow_oscillator;
			RCA_CS_PIN: src_level = external_time_clock_pin;
			RCA_CS_PCLK: src_level = 1'b1;
		endcase
	end

	// peripheral clock source counts every system clock
	wire logic src_tick = on & ((src_sel == RCA_CS_PCLK) |
		(src_level & ~src_prev));
	wire logic half_tick = src_tick & (div_cnt == 16'h0000);
	wire logic sec_tick = half_tick & half_phase;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			src_prev <= 1'b0;
			div_cnt <= 16'h0000;
			half_phase <= 1'b0;
			div_toggle <= 1'b0;
			sync_flag <= 1'b0;
		end else if (clk_en) begin
			src_prev <= src_level;
			sync_flag <= on & (div_cnt == 16'h0000);
			if (src_tick) begin
				div_toggle <= ~div_toggle;
				// software sizes the period for a half second
				div_cnt <= (div_cnt == 16'h0000) ? div_period :
					div_cnt - 16'h0001;
			end
			if (half_tick) begin
				half_phase <= ~half_phase;
			end
		end
	end

	// ==========================================================
	// time and calendar advance
	// ==========================================================
	rca_time_t next_time;
	rca_date_t next_date;
	logic day_wrap;

	always_comb begin
		next_time = now_time;
		day_wrap = 1'b0;
		if (now_time.sec_ones < RCA_NINE) begin
			next_time.sec_ones = now_time.sec_ones + 4'h1;
		end else begin
			next_time.sec_ones = 4'h0;
			if (now_time.sec_tens < RCA_FIVE) begin
				next_time.sec_tens = now_time.sec_tens + 4'h1;
			end else begin
				next_time.sec_tens = 4'h0;
				if (now_time.min_ones < RCA_NINE) begin
					next_time.min_ones = now_time.min_ones + 4'h1;
				end else begin
					next_time.min_ones = 4'h0;
					if (now_time.min_tens < RCA_FIVE[2:0]) begin
						next_time.min_tens = now_time.min_tens + 3'h1;
					end else begin
						next_time.min_tens = 3'h0;
						if (now_time.hr_tens == RCA_HR_TENS_MAX &&
							now_time.hr_ones >= RCA_HR_ONES_MAX) begin
							next_time.hr_tens = 3'h0;
							next_time.hr_ones = 4'h0;
							day_wrap = 1'b1;
						end else if (now_time.hr_ones >= RCA_NINE) begin
							next_time.hr_ones = 4'h0;
							next_time.hr_tens = now_time.hr_tens + 3'h1;
						end else begin
							next_time.hr_ones = now_time.hr_ones + 4'h1;
						end
					end
				end
			end
		end
	end

	always_comb begin
		next_date = now_date;
		next_date.wday = (now_date.wday >= RCA_WDAY_MAX) ? 3'h0 :
			now_date.wday + 3'h1;
		if ({2'h0, now_date.day_tens, now_date.day_ones} >=
			last_day(now_date)) begin
			{next_date.day_tens, next_date.day_ones} = RCA_FIRST[5:0];
			if ({3'h0, now_date.mon_tens, now_date.mon_ones} >=
				RCA_DEC_MONTH) begin
				{next_date.mon_tens, next_date.mon_ones} = RCA_FIRST[4:0];
				// 2099 rolls over to 2000
				if (now_date.yr_ones < RCA_NINE) begin
					next_date.yr_ones = now_date.yr_ones + 4'h1;
				end else begin
					next_date.yr_ones = 4'h0;
					next_date.yr_tens = (now_date.yr_tens < RCA_NINE) ?
						now_date.yr_tens + 4'h1 : 4'h0;
				end
			end else if (now_date.mon_ones >= RCA_NINE) begin
				next_date.mon_ones = 4'h0;
				next_date.mon_tens = 1'b1;
			end else begin
				next_date.mon_ones = now_date.mon_ones + 4'h1;
			end
		end else if (now_date.day_ones >= RCA_NINE) begin
			next_date.day_ones = 4'h0;
			next_date.day_tens = now_date.day_tens + 2'h1;
		end else begin
			next_date.day_ones = now_date.day_ones + 4'h1;
		end
	end

	wire logic wr_open = wr_go & ~locked;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			now_time <= word_time(RCA_RST_WORD);
			now_date <= word_date(RCA_RST_WORD);
		end else if (clk_en) begin
			// a software write wins over a same-cycle count
			if (wr_open && hit(wb_adr_i, RCA_OFF_TIME)) begin
				now_time <= word_time(alias_apply(time_word(now_time),
					wb_dat_i, op, wb_sel_i, RCA_IMPL_TIME));
			end else if (sec_tick) begin
				now_time <= next_time;
			end
			if (wr_open && hit(wb_adr_i, RCA_OFF_DATE)) begin
				now_date <= word_date(alias_apply(date_word(now_date),
					wb_dat_i, op, wb_sel_i, RCA_IMPL_DATE));
			end else if (sec_tick && day_wrap) begin
				now_date <= next_date;
			end
		end
	end

	// ==========================================================
	// alarm compare and repeat
	// ==========================================================
	logic match;
	always_comb begin
		// each coarser interval from ten seconds up adds the next field; the weekday joins the compare for the week interval only
		match = (iv == RCA_IV_HALF) | ~half_phase;
		if (iv >= RCA_IV_TEN_SEC) begin
			match &= now_time.sec_ones == alm_time.sec_ones;
		end
		if (iv >= RCA_IV_MIN) begin
			match &= now_time.sec_tens == alm_time.sec_tens;
		end
		if (iv >= RCA_IV_TEN_MIN) begin
			match &= now_time.min_ones == alm_time.min_ones;
		end
		if (iv >= RCA_IV_HOUR) begin
			match &= now_time.min_tens == alm_time.min_tens;
		end
		if (iv >= RCA_IV_DAY) begin
			match &= {now_time.hr_tens, now_time.hr_ones} ==
				{alm_time.hr_tens, alm_time.hr_ones};
		end
		if (iv == RCA_IV_WEEK) begin
			match &= now_date.wday == alm_date.wday;
		end
		if (iv >= RCA_IV_MONTH) begin
			match &= {now_date.day_tens, now_date.day_ones} ==
				{alm_date.day_tens, alm_date.day_ones};
		end
		if (iv == RCA_IV_YEAR) begin
			match &= {now_date.mon_tens, now_date.mon_ones} ==
				{alm_date.mon_tens, alm_date.mon_ones};
		end
		if (iv > RCA_IV_YEAR) begin
			match = 1'b0;
		end
	end

	// compare runs one cycle after the tick, on the updated time
	wire logic alarm_fire = eval_pend & alarm_en & on & match;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			eval_pend <= 1'b0;
			alarm_pulse <= 1'b0;
			evt_flag <= 1'b0;
		end else if (clk_en) begin
			eval_pend <= half_tick;
			if (alarm_fire) begin
				alarm_pulse <= 1'b1;
			end else if (half_tick) begin
				alarm_pulse <= 1'b0;
			end
			// a new event beats the read that clears the flag
			if (alarm_fire) begin
				evt_flag <= 1'b1;
			end else if (rd_stat_go) begin
				evt_flag <= 1'b0;
			end
		end
	end

	// ==========================================================
	// control registers and alarm registers
	// ==========================================================
	logic [31:0] next_ctrl1;
	always_comb begin
		next_ctrl1 = ctrl1;
		if (alarm_fire) begin
			if (rpt != 8'h00) begin
				next_ctrl1[RCA_C1_RPT_LO +: 8] = rpt - 8'h01;
			end else if (chime) begin
				next_ctrl1[RCA_C1_RPT_LO +: 8] = RCA_RPT_FULL;
			end else begin
				next_ctrl1[RCA_C1_ALARM_EN] = 1'b0;
			end
		end
		if (wr_go && hit(wb_adr_i, RCA_OFF_CTRL1)) begin
			next_ctrl1 = alias_apply(ctrl1, wb_dat_i, op, wb_sel_i,
				RCA_IMPL_CTRL1);
			if (locked && !unlock_granted) begin
				next_ctrl1[RCA_C1_LOCK] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl1 <= RCA_RST_WORD;
			ctrl2 <= RCA_RST_WORD;
			alm_time <= word_time(RCA_RST_WORD);
			alm_date <= word_date(RCA_RST_WORD);
		end else if (clk_en) begin
			ctrl1 <= next_ctrl1;
			if (wr_open && hit(wb_adr_i, RCA_OFF_CTRL2)) begin
				ctrl2 <= alias_apply(ctrl2, wb_dat_i, op, wb_sel_i,
					RCA_IMPL_CTRL2);
			end
			if (wr_go && hit(wb_adr_i, RCA_OFF_ATIME)) begin
				alm_time <= word_time(alias_apply(time_word(alm_time),
					wb_dat_i, op, wb_sel_i, RCA_IMPL_TIME));
			end
			if (wr_go && hit(wb_adr_i, RCA_OFF_ADATE)) begin
				alm_date <= word_date(alias_apply(date_word(alm_date),
					wb_dat_i, op, wb_sel_i, RCA_IMPL_ADATE));
			end
		end
	end

	// ==========================================================
	// output pin
	// ==========================================================
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rtc_pin_out <= 1'b0;
		end else if (clk_en) begin
			rtc_pin_out <= 1'b0;
			if (ctrl1[RCA_C1_OE]) begin
				unique case (out_sel)
					RCA_OS_ALARM: rtc_pin_out <= alarm_pulse;
					RCA_OS_SECONDS: rtc_pin_out <= half_phase;
					RCA_OS_DIVCLK: rtc_pin_out <= div_toggle;
					default: rtc_pin_out <= 1'b0;
				endcase
			end
		end
	end

endmodule

// file: bench/rca_rtc_calendar_assertions.sv
`timescale 1ns/10ps
// ==========
// port checks
module rca_rtc_calendar_assertions
	import rca_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic rtc_pin_out
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst || !clk_en);

	// unimplemented bits of a read word stay low
	property rd_mask(logic [3:0] r, logic [31:0] m);
		wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i[7:4]) == r
			|-> (wb_dat_o & ~m) == 32'h0;
	endproperty

	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held past one cycle");
	ack_resp_a: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered next cycle");
	dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	rst_quiet_a: assert property (disable iff (!clk_en)
		$fell(rst) |-> !wb_ack_o && !rtc_pin_out)
		else $error("outputs active after reset");
	ctrl1_bits_a: assert property (rd_mask(4'h0, RCA_IMPL_CTRL1))
		else $error("control one reserved bit set");
	ctrl2_bits_a: assert property (rd_mask(4'h1, RCA_IMPL_CTRL2))
		else $error("control two reserved bit set");
	stat_bits_a: assert property (rd_mask(4'h3, 32'h27))
		else $error("status reserved bit set");
	time_bits_a: assert property (rd_mask(4'h4, RCA_IMPL_TIME))
		else $error("time reserved bit set");
	adate_bits_a: assert property (rd_mask(4'h7, RCA_IMPL_ADATE))
		else $error("alarm date reserved bit set");
	hole_zero_a: assert property (rd_mask(4'h2, 32'h0))
		else $error("unmapped read not zero");

	cover property (wb_ack_o && !$past(wb_we_i) && wb_dat_o[5]);
	cover property ($rose(rtc_pin_out));
	cover property (wb_ack_o && $past(wb_we_i));
endmodule

// file: bench/rca_rtc_calendar_tb.sv
`timescale 1ns/10ps
module rca_rtc_calendar_tb
	import rca_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ugr = 1'b0;
	logic [7:0] adr = 8'h0;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, rd;
	logic en = 1'b1;
	logic ack, pin;
	logic [2:0] src = 3'h0;
	int cs, r, errors = 0, samples_checked = 0;
	int exp[8];
	int impl[8] = '{RCA_IMPL_CTRL1, RCA_IMPL_CTRL2, 0, 0, RCA_IMPL_TIME,
		RCA_IMPL_DATE, RCA_IMPL_TIME, RCA_IMPL_ADATE};
	int din[$] = '{32'h2402_2806, 32'h2302_2801, 32'h9912_3103};
	int dout[$] = '{32'h2402_2900, 32'h2303_0102, 32'h0001_0104};

	always #50 clk_sys = ~clk_sys;

	rca_rtc_calendar i_dut (.clk_sys(clk_sys), .rst(rst), .clk_en(en),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.crystal_oscillator(src[0]), .internal_slow_oscillator(src[1]),
		.external_time_clock_pin(src[2]), .unlock_granted(ugr),
		.rtc_pin_out(pin));

	// ==========
	// tasks
	task automatic end_of_test();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] e);
		samples_checked++;
		if (got !== e) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, e);
		end
	endtask

	task automatic bus(input logic w, input int a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= 8'(a);
		wdat <= d;
		sel <= s;
		// only the watchdog ends a wait for the answer
		do begin
			@(posedge clk_sys);
		end while (ack !== 1'b1);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	// model: lanes and implemented bits only, lock guards timekeeping
	task automatic wr(input int i, input int k, input logic [31:0] d,
		input logic [3:0] s = 4'hf);
		logic [31:0] lm, m, v;
		bus(1'b1, i * 16 + k * 4, d, s);
		lm = impl[i] & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		m = lm & d;
		v = exp[i];
		case (k)
			0: v = (v & ~lm) | m;
			1: v = v & ~m;
			2: v = v | m;
			default: v = v ^ m;
		endcase
		if (exp[0][11] && i inside {1, 4, 5})
			v = exp[i];
		if (i == 0 && exp[0][11] && !ugr)
			v[11] = 1'b1;
		exp[i] = v;
	endtask

	task automatic rdchk(input int i);
		bus(1'b0, i * 16, 32'h0, 4'hf);
		chk(rd, exp[i]);
	endtask

	// one rising edge on the selected source line only
	task automatic tick();
		@(posedge clk_sys);
		src <= 3'(1 << cs);
		@(posedge clk_sys);
		src <= 3'h0;
		repeat (4) @(posedge clk_sys);
	endtask

	initial begin
		repeat (20000) @(posedge clk_sys);
		errors++;
		end_of_test();
	end

	// ==========
	// main sequence
	initial begin
		r = $urandom(94);
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++)
			rdchk(i);
		// keep run, alarm, lock and reserved interval codes out
		for (int i = 0; i < 8; i++) begin
			for (int k = 0; k < 4; k++) begin
				wr(i, k, $urandom & 32'h77ff_77ff, 4'($urandom));
				rdchk(i);
			end
			wr(i, 0, 32'h0);
		end
		wr(0, 2, 32'h800);
		wr(4, 0, 32'h1234_5600);
		rdchk(4);
		wr(0, 1, 32'h800);
		rdchk(0);
		ugr <= 1'b1;
		wr(0, 1, 32'h800);
		rdchk(0);
		ugr <= 1'b0;
		for (int c = 0; c < 3; c++) begin
			cs = c;
			wr(1, 0, c);
			wr(4, 0, 32'h2359_5900);
			wr(5, 0, din[c]);
			wr(0, 0, 32'h8000);
			tick();
			bus(1'b0, 8'h30, 32'h0, 4'hf);
			chk(rd & 32'h1, 32'h1);
			tick();
			exp[4] = 0;
			exp[5] = dout[c];
			rdchk(4);
			rdchk(5);
		end
		wr(0, 0, 32'h0);
		tick();
		tick();
		rdchk(4);
		// clock enable low must freeze the running counters
		wr(0, 0, 32'h8000);
		en <= 1'b0;
		tick();
		tick();
		en <= 1'b1;
		rdchk(4);
		wr(0, 0, 32'h8002_8080);
		for (int k = 0; k < 4; k++) begin
			tick();
			chk(32'(pin), 32'(k < 3));
			exp[0] = 32'h8080 | (k < 2 ? 32'h8000_0000 : 32'h0)
				| (k == 0 ? 32'h1_0000 : 32'h0);
			rdchk(0);
			bus(1'b0, 8'h30, 32'h0, 4'hf);
			chk(rd & 32'h21, (32'(k < 3) << 5) | 32'(k % 2 == 0));
		end
		wr(0, 0, 32'hc000_8090);
		for (int k = 0; k < 2; k++) begin
			tick();
			chk(32'(pin), 32'(k == 0));
			exp[0] = 32'hc0ff_8090 - k * 32'h1_0000;
			rdchk(0);
		end
		// seconds interval fires only on the whole-second tick
		wr(0, 0, 32'h8101_8000);
		for (int k = 0; k < 2; k++) begin
			tick();
			exp[0] = 32'h8101_8000 - k * 32'h1_0000;
			rdchk(0);
		end
		wr(0, 0, 32'h80a0);
		repeat (2) @(posedge clk_sys);
		r = pin;
		tick();
		chk(32'(pin), 32'(r == 0));
		end_of_test();
	end
endmodule

bind rca_rtc_calendar rca_rtc_calendar_assertions i_chk (.clk_sys(clk_sys),
	.rst(rst), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .rtc_pin_out(rtc_pin_out));
